// ===== emb_top.sv
// embedded memory block: configurable ram with port modes, page decoder and axi4-lite setup
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module emb_top (
   // clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // axi4-lite write address
   input  wire logic [emb_pkg::AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   // axi4-lite read address
   input  wire logic [emb_pkg::AXI_AW-1:0]   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // input side (write port)
   input  wire logic                         in_clk_en,
   input  wire logic                         wr_en,
   input  wire logic [emb_pkg::ADDR_W-1:0]   wr_addr,
   input  wire logic [emb_pkg::DATA_W-1:0]   wr_data,
   // output side (read port)
   input  wire logic                         out_clk_en,
   input  wire logic                         read_strobe,
   input  wire logic [emb_pkg::ADDR_W-1:0]   rd_addr,
   input  wire logic [emb_pkg::PAGE_W-1:0]   page_addr,
   // clears
   input  wire logic                         wr_clear,
   input  wire logic                         rd_clear,
   input  wire logic                         global_clear,
   // read results
   output logic [emb_pkg::DATA_W-1:0]        rd_data,
   output logic [emb_pkg::LOCAL_OUTS-1:0]    local_out,
   output logic [emb_pkg::DATA_W-1:0]        shared_out,
   output logic                              shared_oe
);
   // configuration and state
   logic [31:0]                cfg;
   logic [31:0]                next_cfg;
   logic [15:0]                wcount;
   logic [2:0]                 shape;
   logic [1:0]                 mode;
   logic                       mode_io;
   logic                       mode_single;
   logic                       byp_wdata;
   logic                       byp_waddr;
   logic                       byp_wen;
   logic                       out_reg;
   logic                       deep_en;
   logic [emb_pkg::PAGE_W-1:0] page_code;

   // bus handshake state
   logic                       aw_got;
   logic                       w_got;
   logic                       next_aw_got;
   logic                       next_w_got;
   logic                       next_bvalid;
   logic                       next_rvalid;
   logic [emb_pkg::AXI_AW-1:0] aw_addr_q;
   logic [31:0]                wdata_q;
   logic [3:0]                 wstrb_q;
   logic                       aw_hs;
   logic                       w_hs;
   logic                       ar_hs;
   logic                       wr_fire;
   logic                       wr_ok;
   logic [31:0]                rd_mux;
   logic                       rd_ok;

   // memory side
   logic                       clr_wr;
   logic                       clr_rin;
   logic                       clr_out;
   logic                       rin_en;
   logic [emb_pkg::DATA_W-1:0] wd_q;
   logic [emb_pkg::ADDR_W-1:0] wa_q;
   logic                       we_q;
   logic [emb_pkg::ADDR_W-1:0] ra_q;
   logic                       rs_q;
   logic [emb_pkg::PAGE_W-1:0] pg_q;
   logic [emb_pkg::DATA_W-1:0] eff_wd;
   logic [emb_pkg::ADDR_W-1:0] eff_wa;
   logic                       eff_we;
   logic                       wr_pulse;
   logic [emb_pkg::ADDR_W-1:0] raw_ra;
   logic [emb_pkg::ADDR_W-1:0] eff_ra;
   logic                       eff_rs;
   logic [emb_pkg::PAGE_W-1:0] eff_pg;
   logic                       page_hit;
   logic [emb_pkg::DATA_W-1:0] core_word;

   // configuration fields
   assign shape       = cfg[emb_pkg::CFG_SHAPE_LSB +: 3];
   assign mode        = cfg[emb_pkg::CFG_MODE_LSB +: 2];
   assign mode_io     = (mode == emb_pkg::MODE_IO);
   assign mode_single = (mode == emb_pkg::MODE_SINGLE);
   assign byp_wdata   = cfg[emb_pkg::CFG_BYP_WDATA];
   assign byp_waddr   = cfg[emb_pkg::CFG_BYP_WADDR];
   assign byp_wen     = cfg[emb_pkg::CFG_BYP_WEN];
   assign out_reg     = cfg[emb_pkg::CFG_OUTREG];
   assign deep_en     = cfg[emb_pkg::CFG_DEEP];
   assign page_code   = cfg[emb_pkg::CFG_PAGE_LSB +: emb_pkg::PAGE_W];

   // ------------------------------------------------------------ register bus
   assign aw_hs   = s_axi_awvalid & s_axi_awready;
   assign w_hs    = s_axi_wvalid & s_axi_wready;
   assign ar_hs   = s_axi_arvalid & s_axi_arready;
   assign wr_fire = aw_got & w_got & ~s_axi_bvalid;

   always_comb begin
      next_aw_got = aw_got;
      next_w_got  = w_got;
      next_bvalid = s_axi_bvalid;
      next_rvalid = s_axi_rvalid;
      if (aw_hs) begin
         next_aw_got = 1'b1;
      end
      if (w_hs) begin
         next_w_got = 1'b1;
      end
      if (wr_fire) begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (ar_hs) begin
         next_rvalid = 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // ready flags are registered so every bus output stays a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
      end else begin
         aw_got        <= next_aw_got;
         w_got         <= next_w_got;
         s_axi_awready <= ~next_aw_got & ~next_bvalid;
         s_axi_wready  <= ~next_w_got & ~next_bvalid;
         s_axi_bvalid  <= next_bvalid;
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid  <= next_rvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_q <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   // byte-lane merge into the configuration word, illegal shapes clamp to 2048x1
   always_comb begin
      next_cfg = cfg;
      for (int b = 0; b < 4; b++) begin
         if (wstrb_q[b]) begin
            next_cfg[8*b +: 8] = wdata_q[8*b +: 8];
         end
      end
      next_cfg = next_cfg & emb_pkg::CFG_WMASK;
      if (next_cfg[emb_pkg::CFG_SHAPE_LSB +: 3] > emb_pkg::SHAPE_MAX) begin
         next_cfg[emb_pkg::CFG_SHAPE_LSB +: 3] = emb_pkg::SHAPE_MAX;
      end
   end

   // read-only words accept writes silently; unmapped addresses are an error
   assign wr_ok = (aw_addr_q == emb_pkg::OFF_CFG) || (aw_addr_q == emb_pkg::OFF_STATUS)
                  || (aw_addr_q == emb_pkg::OFF_WCOUNT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg         <= emb_pkg::CFG_RESET;
         s_axi_bresp <= emb_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bresp <= wr_ok ? emb_pkg::RESP_OKAY : emb_pkg::RESP_SLVERR;
         if (aw_addr_q == emb_pkg::OFF_CFG) begin
            cfg <= next_cfg;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         emb_pkg::OFF_CFG: begin
            rd_mux = cfg;
         end
         emb_pkg::OFF_STATUS: begin
            rd_mux[emb_pkg::ST_HIT]            = shared_oe;
            rd_mux[emb_pkg::ST_WPEND]          = we_q;
            rd_mux[emb_pkg::ST_SHAPE_LSB +: 3] = shape;
         end
         emb_pkg::OFF_WCOUNT: begin
            rd_mux[15:0] = wcount;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= emb_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? emb_pkg::RESP_OKAY : emb_pkg::RESP_SLVERR;
      end
   end

   // ------------------------------------------------------------ clock groups
   // both port clocks share aclk here; the groups differ by enable and clear
   assign clr_wr  = ~aresetn | global_clear | wr_clear;
   assign clr_rin = mode_io | mode_single ? clr_wr : (~aresetn | global_clear | rd_clear);
   assign clr_out = ~aresetn | global_clear | rd_clear;
   assign rin_en  = mode_io | mode_single ? in_clk_en : out_clk_en;

   // write input registers, on the input side enable
   always_ff @(posedge aclk) begin
      if (clr_wr) begin
         wd_q <= '0;
         wa_q <= '0;
         we_q <= 1'b0;
      end else if (in_clk_en) begin
         wd_q <= wr_data;
         wa_q <= wr_addr;
         we_q <= wr_en;
      end
   end

   assign eff_wd   = byp_wdata ? wr_data : wd_q;
   assign eff_wa   = byp_waddr ? wr_addr : wa_q;
   assign eff_we   = byp_wen ? wr_en : we_q;
   // the pulse never needs timing from outside, only the enable level
   assign wr_pulse = eff_we & in_clk_en & ~clr_wr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wcount <= 16'h0000;
      end else if (wr_pulse) begin
         wcount <= wcount + 16'h0001;
      end
   end

   // read input registers; single-port reads through the write address
   assign raw_ra = mode_single ? wr_addr : rd_addr;

   always_ff @(posedge aclk) begin
      if (clr_rin) begin
         ra_q <= '0;
         rs_q <= 1'b0;
         pg_q <= '0;
      end else if (rin_en) begin
         ra_q <= raw_ra;
         rs_q <= read_strobe;
         pg_q <= page_addr;
      end
   end

   // with the output stage on, address and strobe come from the input registers
   assign eff_ra = out_reg ? ra_q : raw_ra;
   assign eff_pg = out_reg ? pg_q : page_addr;
   // a single port never reads in a cycle that writes
   assign eff_rs = (out_reg ? rs_q : read_strobe) & ~(mode_single & wr_pulse);
   // blocks of one deep memory share address bits, each owns a page code
   assign page_hit = (eff_pg == page_code);

   emb_mem_core u_core (
      .aclk     (aclk),
      .shape    (shape),
      .wr_pulse (wr_pulse),
      .wr_addr  (eff_wa),
      .wr_data  (eff_wd),
      .rd_addr  (eff_ra),
      .rd_word  (core_word)
   );

   // output registers; every read result leaves from a flop
   always_ff @(posedge aclk) begin
      if (clr_out) begin
         rd_data    <= '0;
         local_out  <= '0;
         shared_out <= '0;
         shared_oe  <= 1'b0;
      end else if (out_clk_en && eff_rs) begin
         rd_data    <= core_word;
         local_out  <= {core_word[0], core_word[8:0]};
         shared_out <= core_word;
         // exactly one page code matches any page value, so one driver per line
         shared_oe  <= deep_en & page_hit;
      end
   end
endmodule : emb_top
`default_nettype wire

// ===== emb_pkg.sv
// constants shared by the embedded memory block and its storage core
//
// Summary of operation
// - five shapes, 2048 bits: 128x16 up to 2048x1
// - write data, address, enable captured by input registers
// - optional output register adds one pipeline stage
// - dual-port: read and write in one period
// - write pulse made internally from registered enable
// - blocks in parallel share address, no added latency
// - programmable page decoder enables shared output driver
// - 8192 words: four blocks, eleven plus two bits
// - only the selected page block drives shared line
// - page decode: never two drivers, never floating
// - true dual-port built from two or four blocks
// - read/write mode: write group on write side
// - read/write mode: read group on read side
// - enable and clear act per side separately
// - input/output mode: all inputs on input side
// - input/output mode: output side clocks only outputs
// - input/output mode: separate input and output enables
// - every register clearable by local, global, reset; here the configuration, write count and bus registers clear on reset only
// - single-port: shared address, no simultaneous read/write
// - ten outputs to local routing, nine distinct
// - each input or output register individually bypassable; here only the write inputs, read inputs share one bit, outputs fixed
package emb_pkg;
   // storage geometry
   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 11;
   localparam int ROWS       = 128;
   localparam int PAGE_W     = 2;
   localparam int LOCAL_OUTS = 10;
   localparam logic [2:0] SHAPE_MAX = 3'h4;

   // register bus
   localparam int AXI_AW = 8;
   localparam logic [AXI_AW-1:0] OFF_CFG    = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_WCOUNT = 8'h08;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // configuration word layout
   localparam int CFG_SHAPE_LSB = 0;
   localparam int CFG_MODE_LSB  = 4;
   localparam int CFG_BYP_WDATA = 8;
   localparam int CFG_BYP_WADDR = 9;
   localparam int CFG_BYP_WEN   = 10;
   localparam int CFG_OUTREG    = 11;
   localparam int CFG_DEEP      = 12;
   localparam int CFG_PAGE_LSB  = 14;
   localparam logic [31:0] CFG_WMASK = 32'h0000_df37;
   localparam logic [31:0] CFG_RESET = 32'h0000_0810;

   // port modes
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_RW     = 2'h1;
   localparam logic [1:0] MODE_IO     = 2'h2;

   // status word layout
   localparam int ST_HIT       = 0;
   localparam int ST_WPEND     = 1;
   localparam int ST_SHAPE_LSB = 4;
endpackage : emb_pkg

// ===== emb_mem_core.sv
// storage array of the embedded memory block, reshaped by the shape code
`timescale 1ns/1ps
`default_nettype none
module emb_mem_core (
   // clock
   input  wire logic                       aclk,
   // shape code, 0 = 128x16 .. 4 = 2048x1
   input  wire logic [2:0]                 shape,
   // write side
   input  wire logic                       wr_pulse,
   input  wire logic [emb_pkg::ADDR_W-1:0] wr_addr,
   input  wire logic [emb_pkg::DATA_W-1:0] wr_data,
   // read side
   input  wire logic [emb_pkg::ADDR_W-1:0] rd_addr,
   output logic      [emb_pkg::DATA_W-1:0] rd_word
);
   logic [2:0]                 lane_log;
   logic [3:0]                 lane_mask;
   logic [4:0]                 word_w;
   logic [emb_pkg::ADDR_W-1:0] wr_shift;
   logic [emb_pkg::ADDR_W-1:0] rd_shift;
   logic [6:0]                 wr_row;
   logic [6:0]                 rd_row;
   logic [3:0]                 wr_slot;
   logic [3:0]                 rd_slot;
   logic [emb_pkg::DATA_W-1:0] row_bits;

   // a 16-bit row holds 2^shape words of 16>>shape bits each
   assign lane_log  = 3'h4 - shape;
   assign lane_mask = 4'((5'h01 << lane_log) - 5'h01);
   assign word_w    = 5'h10 >> shape;
   assign wr_shift  = wr_addr >> shape;
   assign rd_shift  = rd_addr >> shape;
   assign wr_row    = wr_shift[6:0];
   assign rd_row    = rd_shift[6:0];
   assign wr_slot   = wr_addr[3:0] & ~(4'hf << shape);
   assign rd_slot   = rd_addr[3:0] & ~(4'hf << shape);

   // one single-bit array per lane keeps every array element single-driven
   for (genvar j = 0; j < emb_pkg::DATA_W; j++) begin : g_lane
      logic       lane [0:emb_pkg::ROWS-1];
      logic [3:0] pos;
      logic [3:0] src;
      logic       hit;
      assign pos = 4'(j);
      assign hit = ((pos >> lane_log) == wr_slot);
      assign src = 4'((rd_slot << lane_log) | pos);
      // contents are never cleared, only overwritten
      always_ff @(posedge aclk) begin
         if (wr_pulse && hit) begin
            lane[wr_row] <= wr_data[pos & lane_mask];
         end
      end
      assign row_bits[j] = lane[rd_row];
      assign rd_word[j]  = (5'(j) < word_w) ? row_bits[src] : 1'b0;
   end
endmodule : emb_mem_core
`default_nettype wire

// ===== emb_top_properties.sv
// concurrent checks on the ports of the embedded memory block
`timescale 1ns/1ps
`default_nettype none
module emb_top_properties (
   // clock and reset
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   // register bus, watched for the configuration word
   input  wire logic [emb_pkg::AXI_AW-1:0]     s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   input  wire logic                           s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic                           s_axi_wvalid,
   input  wire logic                           s_axi_wready,
   input  wire logic                           s_axi_bvalid,
   input  wire logic                           s_axi_rvalid,
   // user side
   input  wire logic                           in_clk_en,
   input  wire logic                           out_clk_en,
   input  wire logic                           wr_en,
   input  wire logic                           read_strobe,
   input  wire logic [emb_pkg::PAGE_W-1:0]     page_addr,
   input  wire logic                           wr_clear,
   input  wire logic                           rd_clear,
   input  wire logic                           global_clear,
   input  wire logic [emb_pkg::DATA_W-1:0]     rd_data,
   input  wire logic [emb_pkg::LOCAL_OUTS-1:0] local_out,
   input  wire logic [emb_pkg::DATA_W-1:0]     shared_out,
   input  wire logic                           shared_oe
);
   logic [31:0] cfg_q;
   // limitation: assumes address and data are taken at one edge, as the bench offers them
   always_ff @(posedge aclk) begin
      if (!aresetn)
         cfg_q <= emb_pkg::CFG_RESET;
      else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == emb_pkg::OFF_CFG)
         cfg_q <= s_axi_wdata & emb_pkg::CFG_WMASK;
   end

   sequence s_req(logic hit);
      cfg_q[12] && cfg_q[5:4] != 2'h0 && read_strobe && in_clk_en && out_clk_en && !wr_en
      && !(rd_clear || wr_clear || global_clear) && ((page_addr == cfg_q[15:14]) == hit);
   endsequence
   sequence s_hold;
      out_clk_en && !(rd_clear || wr_clear || global_clear);
   endsequence

   AST_LAT_REG: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_q[11] ##0 s_req(1'b1) ##1 s_hold |=> shared_oe)
      else $error("registered page read not driven after two edges");
   AST_LAT_BYP: assert property (@(posedge aclk) disable iff (!aresetn)
      !cfg_q[11] ##0 s_req(1'b1) |=> shared_oe)
      else $error("bypassed page read not driven after one edge");
   AST_PAGE_MISS: assert property (@(posedge aclk) disable iff (!aresetn)
      !cfg_q[11] ##0 s_req(1'b0) |=> !shared_oe)
      else $error("unselected page drives the shared line");
   AST_OUT_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
      !out_clk_en && !rd_clear && !global_clear |=> $stable(rd_data) && $stable(shared_oe))
      else $error("output moved with output enable low");
   AST_GLOBAL_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      global_clear |=> rd_data == '0 && local_out == '0 && !shared_oe)
      else $error("global clear left outputs set");
   AST_RD_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_clear |=> rd_data == '0 && !shared_oe)
      else $error("read clear left outputs set");
   AST_RESET_ZERO: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> rd_data == '0 && !shared_oe && !s_axi_bvalid && !s_axi_rvalid)
      else $error("reset left outputs set");
   AST_LOCAL_DUP: assert property (@(posedge aclk) disable iff (!aresetn)
      local_out == {rd_data[0], rd_data[8:0]})
      else $error("local routing outputs not duplicated");
   AST_SHARED_COPY: assert property (@(posedge aclk) disable iff (!aresetn)
      shared_out == rd_data)
      else $error("shared line data differs from read data");
endmodule : emb_top_properties

bind emb_top emb_top_properties u_props (.*);
`default_nettype wire

// ===== emb_user_model.sv
// fabric user logic driving the write and read ports of the memory block
`timescale 1ns/1ps
`default_nettype none
module emb_user_model (
   // clock
   input  wire logic                       aclk,
   // write port
   output logic                            wr_en,
   output logic [emb_pkg::ADDR_W-1:0]      wr_addr,
   output logic [emb_pkg::DATA_W-1:0]      wr_data,
   // read port
   output logic                            read_strobe,
   output logic [emb_pkg::ADDR_W-1:0]      rd_addr,
   output logic [emb_pkg::PAGE_W-1:0]      page_addr
);
   initial begin
      {wr_en, read_strobe} = 2'h0;
      {wr_addr, rd_addr, wr_data, page_addr} = '0;
   end
   // back to back calls keep the enable high; only clock timing is met here
   task automatic write(input logic [emb_pkg::ADDR_W-1:0] a, input logic [emb_pkg::DATA_W-1:0] d);
      @(posedge aclk);
      wr_en   <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
   endtask : write
   // released lines show the inverse so a late sample cannot match by luck
   task automatic idle();
      @(posedge aclk);
      wr_en   <= 1'b0;
      wr_addr <= ~wr_addr;
      wr_data <= ~wr_data;
   endtask : idle
   // write address follows too, as single-port mode reads through it
   task automatic read(input logic [emb_pkg::ADDR_W-1:0] a, input logic [emb_pkg::PAGE_W-1:0] p);
      @(posedge aclk);
      read_strobe <= 1'b1;
      rd_addr     <= a;
      wr_addr     <= a;
      page_addr   <= p;
      @(posedge aclk);
      read_strobe <= 1'b0;
      rd_addr     <= ~a;
      wr_addr     <= ~a;
      page_addr   <= ~p;
   endtask : read
endmodule : emb_user_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the embedded memory block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {int n; logic [16:0] v;} emb_note_t;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, page_addr;
   logic        in_clk_en, out_clk_en, wr_clear, rd_clear, global_clear, wr_en, read_strobe, shared_oe;
   logic [10:0] wr_addr, rd_addr, ad;
   logic [15:0] wr_data, rd_data, shared_out, dd;
   logic [9:0]  local_out;
   int          err_count, checks, lat, wc;
   emb_note_t   nt, nw;
   emb_note_t   rd_q[$];
   logic [33:0] bus_q[$];

   emb_top dut (.*);
   emb_user_model u_user (.*);
   always #2.5 aclk = ~aclk;

   task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
      logic aw, w;
      {aw, w} = 2'h0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         aw = aw | (s_axi_awready === 1'b1);
         w  = w | (s_axi_wready === 1'b1);
         if (aw)
            s_axi_awvalid <= 1'b0;
         if (w)
            s_axi_wvalid <= 1'b0;
      end while (!(aw && w));
      while (s_axi_bvalid !== 1'b1)
         @(posedge aclk);
      check({32'h0, s_axi_bresp}, {32'h0, resp}, "write response");
      s_axi_bready <= 1'b0;
      s_axi_awaddr <= ~a;
      s_axi_wdata  <= ~d;
      @(posedge aclk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
      bus_q.push_back(exp);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
         @(posedge aclk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr  <= ~a;
      do
         @(posedge aclk);
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd
   task automatic rd(input logic [10:0] a, input logic [1:0] p, input logic [16:0] exp);
      nt.n = lat + 2;
      nt.v = exp;
      rd_q.push_back(nt);
      u_user.read(a, p);
      repeat (lat + 1) @(posedge aclk);
   endtask : rd

   always @(posedge aclk)
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && bus_q.size() > 0)
         check({s_axi_rresp, s_axi_rdata}, bus_q.pop_front(), "register read");
   initial forever begin
      wait (rd_q.size() > 0);
      repeat (rd_q[0].n) @(negedge aclk);
      nw = rd_q.pop_front();
      check({17'h0, shared_oe, rd_data}, {17'h0, nw.v}, "user read");
   end
   initial begin
      #100000;
      err_count++;
      results();
   end

   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {wr_clear, rd_clear, global_clear} = 3'h0;
      {in_clk_en, out_clk_en} = 2'h3;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      wc = $urandom(71968);
      axi_rd(emb_pkg::OFF_CFG, {emb_pkg::RESP_OKAY, emb_pkg::CFG_RESET});
      axi_rd(emb_pkg::OFF_WCOUNT, {emb_pkg::RESP_OKAY, 32'h0});
      axi_rd(8'h0c, {emb_pkg::RESP_SLVERR, 32'h0});
      axi_wr(8'h0c, 32'h0, emb_pkg::RESP_SLVERR);
      axi_wr(emb_pkg::OFF_STATUS, 32'hffff_ffff, emb_pkg::RESP_OKAY);
      axi_rd(emb_pkg::OFF_STATUS, {emb_pkg::RESP_OKAY, 32'h0});
      axi_wr(emb_pkg::OFF_CFG, 32'hffff_ffff, emb_pkg::RESP_OKAY);
      axi_rd(emb_pkg::OFF_CFG, {emb_pkg::RESP_OKAY, 32'h0000_df34});
      $display("test registers done");
      {lat, wc} = {32'd2, 32'd0};
      // mode walks single, read/write and input/output across the five shapes
      for (int s = 0; s < 5; s++) begin
         logic [15:0] d1, d2, m;
         ad = 11'($urandom) & 11'((128 << s) - 1);
         m  = 16'((1 << (16 >> s)) - 1);
         d1 = 16'($urandom);
         d2 = 16'($urandom);
         axi_wr(emb_pkg::OFF_CFG, 32'h800 | 32'((s % 2) * 'h700 + (s % 3) * 'h10 + s), emb_pkg::RESP_OKAY);
         u_user.write(ad, d1);
         u_user.write(ad ^ 11'h1, d2);
         u_user.idle();
         repeat (2) @(posedge aclk);
         rd(ad, 2'h0, {1'b0, d1 & m});
         rd(ad ^ 11'h1, 2'h0, {1'b0, d2 & m});
         wc += 2;
      end
      axi_rd(emb_pkg::OFF_STATUS, {emb_pkg::RESP_OKAY, 32'h40});
      $display("test shapes done");
      ad = 11'($urandom) & 11'h7f;
      dd = 16'($urandom);
      for (int o = 1; o >= 0; o--) begin
         axi_wr(emb_pkg::OFF_CFG, 32'h9010 | (32'(o) << 11), emb_pkg::RESP_OKAY);
         lat = o + 1;
         if (o == 1) begin
            u_user.write(ad, dd);
            u_user.idle();
            wc++;
         end
         for (int p = 0; p < 4; p++)
            rd(ad, 2'(p), {1'(p == 2), dd});
      end
      $display("test pages done");
      in_clk_en <= 1'b0;
      u_user.write(ad, ~dd);
      u_user.idle();
      in_clk_en <= 1'b1;
      rd(ad, 2'h2, {1'b1, dd});
      wr_clear <= 1'b1;
      u_user.write(ad, ~dd);
      u_user.idle();
      wr_clear <= 1'b0;
      rd(ad, 2'h2, {1'b1, dd});
      global_clear <= 1'b1;
      @(posedge aclk);
      global_clear <= 1'b0;
      // configuration is rewritten in case the global clear reached it too
      axi_wr(emb_pkg::OFF_CFG, 32'h9010, emb_pkg::RESP_OKAY);
      out_clk_en <= 1'b0;
      rd(ad, 2'h2, {1'b0, 16'h0});
      out_clk_en <= 1'b1;
      rd(ad, 2'h2, {1'b1, dd});
      rd_clear <= 1'b1;
      @(posedge aclk);
      rd_clear <= 1'b0;
      rd(ad, 2'h3, {1'b0, dd});
      axi_rd(emb_pkg::OFF_WCOUNT, {emb_pkg::RESP_OKAY, 32'(wc)});
      repeat (4) @(posedge aclk);
      $display("test clears done");
      results();
   end
endmodule : tb_top
`default_nettype wire
